// [design/stc_pkg.sv]
// Package: register map, field layout, command codes and carriers of the SDRAM timing control block
package stc_pkg;

  // Register map (byte addresses on the AHB-Lite port, low address bits decoded)
  localparam int unsigned ADDR_DEC_W = 8;
  localparam logic [ADDR_DEC_W-1:0] TMG_OFFSET = 8'h00;
  localparam logic [ADDR_DEC_W-1:0] CFG_OFFSET = 8'h04;
  localparam logic [ADDR_DEC_W-1:0] STAT_OFFSET = 8'h08;

  // Timing control register, 16 bits
  localparam int unsigned TMG_W = 16;
  localparam logic [TMG_W-1:0] TMG_RESET = 16'h0000;
  localparam int unsigned PRECHARGE_WAIT_LSB = 14;
  localparam int unsigned ROW_COL_DELAY_LSB = 12;
  localparam int unsigned WRITE_PRECHARGE_DELAY_LSB = 10;
  localparam int unsigned REFRESH_ROW_ASSERT_LSB = 8;
  localparam int unsigned BANK_OPERATION_SELECT_BIT = 7;

  // Configuration register: bit 0 says synchronous DRAM is the connected memory
  localparam int unsigned CFG_W = 1;
  localparam logic [CFG_W-1:0] CFG_RESET = 1'h0;
  localparam int unsigned CFG_SDRAM_SEL_BIT = 0;

  // Cycle counts
  localparam int unsigned GAP_W = 5;
  localparam logic [GAP_W-1:0] GAP_ZERO = 5'h00;
  localparam logic [GAP_W-1:0] GAP_ONE = 5'h01;
  localparam logic [GAP_W-1:0] TPC_BASE = 5'h01;
  localparam logic [GAP_W-1:0] RCD_BASE = 5'h01;
  localparam logic [GAP_W-1:0] WRITE_PRECHARGE_DELAY_BASE = 5'h01;
  localparam logic [GAP_W-1:0] WRITE_PRECHARGE_DELAY_MAX = 5'h03;
  localparam logic [GAP_W-1:0] REFRESH_ROW_ASSERT_TIME_BASE = 5'h02;
  localparam logic [GAP_W-1:0] SRX_BASE = 5'h02;
  localparam logic [GAP_W-1:0] SRX_STEP = 5'h03;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;
  localparam logic [31:0] HRDATA_ZERO = 32'h0000_0000;

  localparam int unsigned ROW_W = 13;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RW = 3'h2,
    ST_REF = 3'h4
  } stc_state_e;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_READ = 3'h2,
    CMD_WRITE = 3'h3,
    CMD_PRE = 3'h4,
    CMD_PALL = 3'h5,
    CMD_REF = 3'h6
  } stc_cmd_e;

  typedef struct packed {
    logic write;
    logic [ROW_W-1:0] row;
  } stc_req_s;

  typedef struct packed {
    stc_cmd_e code;
    logic auto_pre;
    logic [ROW_W-1:0] row;
  } stc_cmd_s;

endpackage : stc_pkg

// [design/stc_sdram_timing_control.sv]
// SDRAM command sequencer with its timing control register, reached over AHB-Lite
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Before a bank-active, wait 1 to 4 cycles for precharge wait codes 00 to 11.
// - After precharge-all in refresh or precharge in bank mode, wait one cycle less.
// - After leaving self-refresh, wait 2, 5, 8 or 11 cycles by precharge wait code.
// - Read or write follows bank-active by 1 to 4 cycles by row-column delay code.
// - Write-precharge delay codes 00, 01, 10 give 1, 2, 3 cycles.
// - After a write, no bank-active until precharge wait plus write-precharge delay.
// - Write-precharge delay counts only while synchronous DRAM is the selected memory.
// - Refresh row-assert codes 00 to 11 give 2 to 5 cycles.
// - After auto-refresh, no bank-active until precharge wait plus row-assert time.
// - Bank-operation select 0 chooses auto-precharge mode.
// - Reset clears the timing control register to zero.
module stc_sdram_timing_control (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Access requests from the bus state controller
  input wire logic req_valid,
  input wire stc_pkg::stc_req_s req,
  output logic req_ack,
  // Refresh and self-refresh events
  input wire logic refresh_req,
  input wire logic self_refresh_exit,
  // SDRAM command
  output stc_pkg::stc_cmd_s cmd
);
  import stc_pkg::*;

  // Bus slave state
  logic hreadyout_reg;
  logic hresp_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic wr_pend_reg;
  logic wr_pend_next;
  logic [ADDR_DEC_W-1:0] wr_addr_reg;
  logic [ADDR_DEC_W-1:0] wr_addr_next;

  // Registers
  logic [TMG_W-1:0] tmg_reg;
  logic [TMG_W-1:0] tmg_next;
  logic [CFG_W-1:0] cfg_reg;
  logic [CFG_W-1:0] cfg_next;

  // Sequencer state
  stc_state_e state_reg;
  stc_state_e state_next;
  logic [GAP_W-1:0] gap_reg;
  logic [GAP_W-1:0] gap_next;
  logic row_open_reg;
  logic row_open_next;
  logic [ROW_W-1:0] open_row_reg;
  logic [ROW_W-1:0] open_row_next;
  logic ref_pend_reg;
  logic ref_pend_next;
  logic srx_pend_reg;
  logic srx_pend_next;
  logic ref_clear;
  logic srx_clear;
  stc_cmd_s cmd_reg;
  stc_cmd_s cmd_next;
  logic req_ack_reg;
  logic req_ack_next;

  // Address phase decode
  wire addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire rd_start = addr_phase & ~hwrite;
  wire wr_start = addr_phase & hwrite & (hsize == HSIZE_WORD);
  wire [ADDR_DEC_W-1:0] addr_low = haddr[ADDR_DEC_W-1:0];
  wire wr_tmg = wr_pend_reg & (wr_addr_reg == TMG_OFFSET);
  wire wr_cfg = wr_pend_reg & (wr_addr_reg == CFG_OFFSET);

  // Field decode
  wire [1:0] precharge_wait = tmg_reg[PRECHARGE_WAIT_LSB +: 2];
  wire [1:0] row_col_delay = tmg_reg[ROW_COL_DELAY_LSB +: 2];
  wire [1:0] write_precharge_delay = tmg_reg[WRITE_PRECHARGE_DELAY_LSB +: 2];
  wire [1:0] refresh_row_assert_time = tmg_reg[REFRESH_ROW_ASSERT_LSB +: 2];
  wire bank_operation_select = tmg_reg[BANK_OPERATION_SELECT_BIT];
  wire sdram_sel = cfg_reg[CFG_SDRAM_SEL_BIT];
  wire bank_mode = bank_operation_select;

  // Cycle counts; each is the number of NOP cycles inserted before the next command
  wire [GAP_W-1:0] tpc_cyc = {3'h0, precharge_wait} + TPC_BASE;
  wire [GAP_W-1:0] tpc_short_cyc = {3'h0, precharge_wait};
  wire [GAP_W-1:0] srx_cyc = ({3'h0, precharge_wait} * SRX_STEP) + SRX_BASE;
  wire [GAP_W-1:0] rcd_cyc = {3'h0, row_col_delay} + RCD_BASE;
  // The prohibited code is clamped so a stray write cannot stretch the gap
  wire [GAP_W-1:0] write_precharge_delay_raw = {3'h0, write_precharge_delay} + WRITE_PRECHARGE_DELAY_BASE;
  wire [GAP_W-1:0] write_precharge_delay_cyc = (write_precharge_delay_raw > WRITE_PRECHARGE_DELAY_MAX) ? WRITE_PRECHARGE_DELAY_MAX : write_precharge_delay_raw;
  // Without synchronous DRAM the write recovery adds no cycles
  wire [GAP_W-1:0] write_precharge_delay_eff = sdram_sel ? write_precharge_delay_cyc : GAP_ZERO;
  wire [GAP_W-1:0] refresh_row_assert_time_cyc = {3'h0, refresh_row_assert_time} + REFRESH_ROW_ASSERT_TIME_BASE;
  wire [GAP_W-1:0] wr_lock_cyc = tpc_cyc + write_precharge_delay_eff;
  wire [GAP_W-1:0] ref_lock_cyc = tpc_cyc + refresh_row_assert_time_cyc;

  wire gap_done = (gap_reg == GAP_ZERO);
  wire row_hit = row_open_reg & (open_row_reg == req.row);
  // An acknowledged request is still on the pins at the next edge; taking it again would repeat it
  wire req_take = req_valid & ~req_ack_reg;

  // Status word
  // Row open, refresh pending, exit pending, state, memory select, gap counter
  wire [31:0] status_word = {16'h0000, 4'h0, row_open_reg, ref_pend_reg, srx_pend_reg,
                             state_reg, sdram_sel, gap_reg};

  // Register write path, data phase of a write
  always_comb
  begin
    tmg_next = tmg_reg;
    cfg_next = cfg_reg;
    if (wr_tmg)
    begin
      tmg_next = hwdata[TMG_W-1:0];
    end
    if (wr_cfg)
    begin
      cfg_next = hwdata[CFG_W-1:0];
    end
  end

  // Read data is registered at the address phase; next values forward a write in flight
  always_comb
  begin
    hrdata_next = HRDATA_ZERO;
    if (rd_start)
    begin
      case (addr_low)
        TMG_OFFSET: hrdata_next = {16'h0000, tmg_next};
        CFG_OFFSET: hrdata_next = {31'h0000_0000, cfg_next};
        STAT_OFFSET: hrdata_next = status_word;
        default: hrdata_next = HRDATA_ZERO;
      endcase
    end
  end

  assign wr_pend_next = wr_start;
  assign wr_addr_next = wr_start ? addr_low : wr_addr_reg;

  // Pending events; a new event in the clearing cycle stays pending
  assign ref_pend_next = refresh_req | (ref_pend_reg & ~ref_clear);
  assign srx_pend_next = self_refresh_exit | (srx_pend_reg & ~srx_clear);

  // Command sequencer
  always_comb
  begin
    state_next = state_reg;
    gap_next = gap_done ? GAP_ZERO : (gap_reg - GAP_ONE);
    row_open_next = row_open_reg;
    open_row_next = open_row_reg;
    ref_clear = 1'b0;
    srx_clear = 1'b0;
    req_ack_next = 1'b0;
    cmd_next.code = CMD_NOP;
    cmd_next.auto_pre = 1'b0;
    cmd_next.row = open_row_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (gap_done)
        begin
          if (srx_pend_reg)
          begin
            srx_clear = 1'b1;
            gap_next = srx_cyc;
            row_open_next = 1'b0;
          end
          else if (ref_pend_reg)
          begin
            cmd_next.code = CMD_PALL;
            row_open_next = 1'b0;
            gap_next = tpc_short_cyc;
            state_next = ST_REF;
          end
          else if (req_take)
          begin
            if (bank_mode & row_hit)
            begin
              // Open row hit: go straight to the column command
              state_next = ST_RW;
            end
            else if (bank_mode & row_open_reg)
            begin
              cmd_next.code = CMD_PRE;
              row_open_next = 1'b0;
              gap_next = tpc_short_cyc;
            end
            else
            begin
              cmd_next.code = CMD_ACT;
              cmd_next.row = req.row;
              row_open_next = 1'b1;
              open_row_next = req.row;
              gap_next = rcd_cyc;
              state_next = ST_RW;
            end
          end
        end
      end
      ST_RW:
      begin
        if (gap_done)
        begin
          cmd_next.code = req.write ? CMD_WRITE : CMD_READ;
          cmd_next.auto_pre = ~bank_mode;
          cmd_next.row = open_row_reg;
          req_ack_next = 1'b1;
          state_next = ST_IDLE;
          if (bank_mode)
          begin
            // Row stays open; a later precharge waits out the write recovery
            gap_next = req.write ? write_precharge_delay_eff : GAP_ZERO;
          end
          else
          begin
            row_open_next = 1'b0;
            gap_next = req.write ? wr_lock_cyc : tpc_cyc;
          end
        end
      end
      ST_REF:
      begin
        if (gap_done)
        begin
          cmd_next.code = CMD_REF;
          ref_clear = 1'b1;
          gap_next = ref_lock_cyc;
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
        gap_next = GAP_ZERO;
        row_open_next = 1'b0;
      end
    endcase
  end

  // Bus slave flops; zero wait states, always OKAY
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= HRESP_OKAY;
      hrdata_reg <= HRDATA_ZERO;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= TMG_OFFSET;
    end
    else
    begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= HRESP_OKAY;
      hrdata_reg <= hrdata_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
    end
  end

  // Register flops
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      tmg_reg <= TMG_RESET;
      cfg_reg <= CFG_RESET;
    end
    else
    begin
      tmg_reg <= tmg_next;
      cfg_reg <= cfg_next;
    end
  end

  // Sequencer flops
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_IDLE;
      gap_reg <= GAP_ZERO;
      row_open_reg <= 1'b0;
      open_row_reg <= '0;
      ref_pend_reg <= 1'b0;
      srx_pend_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      gap_reg <= gap_next;
      row_open_reg <= row_open_next;
      open_row_reg <= open_row_next;
      ref_pend_reg <= ref_pend_next;
      srx_pend_reg <= srx_pend_next;
    end
  end

  // Output flops
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      cmd_reg.code <= CMD_NOP;
      cmd_reg.auto_pre <= 1'b0;
      cmd_reg.row <= '0;
      req_ack_reg <= 1'b0;
    end
    else
    begin
      cmd_reg <= cmd_next;
      req_ack_reg <= req_ack_next;
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign hrdata = hrdata_reg;
  assign cmd = cmd_reg;
  assign req_ack = req_ack_reg;

endmodule : stc_sdram_timing_control

`default_nettype wire

// [tb/stc_props.sv]
// Checker: command spacing and reset behaviour at the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module stc_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Sequencer outputs
  input wire logic req_ack,
  input wire stc_pkg::stc_cmd_s cmd
);
  import stc_pkg::*;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  act_then_nop_a: assert property (cmd.code == CMD_ACT |=> cmd.code == CMD_NOP)
    else $error("command right after bank-active");
  ack_on_rw_a: assert property ($rose(req_ack) |-> cmd.code inside {CMD_READ, CMD_WRITE})
    else $error("acknowledge without read or write");
  pall_ref_a: assert property (cmd.code == CMD_PALL |-> ##[1:4] cmd.code == CMD_REF)
    else $error("refresh late after precharge-all");
  ref_gap_a: assert property (cmd.code == CMD_REF |=> cmd.code == CMD_NOP [*3])
    else $error("command too soon after refresh");
  read_gap_a: assert property (cmd.code == CMD_READ && cmd.auto_pre |=> cmd.code == CMD_NOP)
    else $error("command too soon after read");
  write_gap_a: assert property (cmd.code == CMD_WRITE && cmd.auto_pre |=> cmd.code == CMD_NOP)
    else $error("command too soon after write");
  pre_act_a: assert property (cmd.code == CMD_PRE |-> ##[1:4] cmd.code == CMD_ACT)
    else $error("bank-active late after precharge");
  reset_idle_a: assert property ($rose(reset_n) |-> cmd.code == CMD_NOP && !req_ack)
    else $error("sequencer busy after reset");
  cover property (cmd.code == CMD_PALL);
  cover property (cmd.code == CMD_PRE);
  cover property (req_ack && cmd.code == CMD_WRITE);
endmodule : stc_props
bind stc_sdram_timing_control stc_props u_props (.mclk(mclk), .reset_n(reset_n), .req_ack(req_ack), .cmd(cmd));
`default_nettype wire

// [tb/stc_sdram_model.sv]
// SDRAM-side model: logs each command with the idle gap before it
`timescale 1ns/1ps
`default_nettype none
module stc_sdram_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Command from the controller
  input wire stc_pkg::stc_cmd_s cmd
);
  import stc_pkg::*;
  logic [4:0] idle_reg;
  logic [2:0] last_reg;
  logic ap_reg;
  logic [ROW_W-1:0] act_row_reg;
  logic [4:0] gap_of [8];
  logic [2:0] prev_of [8];
  // Sampled mid-cycle so the log is settled when the bench reads it after a rising edge
  always_ff @(negedge mclk)
  begin
    if (!reset_n)
    begin
      idle_reg <= GAP_ZERO;
      last_reg <= CMD_NOP;
      ap_reg <= 1'b0;
      act_row_reg <= '0;
    end
    else if (cmd.code == CMD_NOP)
    begin
      idle_reg <= idle_reg + GAP_ONE;
    end
    else
    begin
      gap_of[cmd.code] <= idle_reg;
      prev_of[cmd.code] <= last_reg;
      last_reg <= cmd.code;
      ap_reg <= cmd.auto_pre;
      idle_reg <= GAP_ZERO;
      if (cmd.code == CMD_ACT)
      begin
        act_row_reg <= cmd.row;
      end
    end
  end
endmodule : stc_sdram_model
`default_nettype wire

// [tb/tb.sv]
// Testbench: registers and command spacing of the SDRAM timing control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import stc_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic req_valid = 1'b0;
  stc_req_s req = '0;
  logic refresh_req = 1'b0;
  logic sr_exit = 1'b0;
  logic hreadyout, hresp, req_ack;
  logic [31:0] hrdata, rd;
  stc_cmd_s cmd;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int d0, d3;
  always #4 mclk = ~mclk;
  stc_sdram_timing_control dut (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .req_valid(req_valid), .req(req), .req_ack(req_ack), .refresh_req(refresh_req),
    .self_refresh_exit(sr_exit), .cmd(cmd));
  stc_sdram_model p (.mclk(mclk), .reset_n(reset_n), .cmd(cmd));
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic acc(input logic w, input logic [12:0] r);
    req_valid <= 1'b1;
    req <= '{write: w, row: r};
    do @(posedge mclk); while (req_ack !== 1'b1);
  endtask : acc
  task automatic idle(input int n);
    req_valid <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask : idle
  task automatic srx(output int d);
    sr_exit <= 1'b1;
    @(posedge mclk);
    sr_exit <= 1'b0;
    d = cyc;
    acc(1'b0, 13'h0009);
    d = cyc - d;
    idle(12);
  endtask : srx
  function automatic logic [31:0] g(input stc_cmd_e c);
    return {27'h0, p.gap_of[c]};
  endfunction : g
  function automatic logic [31:0] mk(input int tp, input int rc, input int wl, input int ra, input logic b);
    return {16'h0, tp[1:0], rc[1:0], wl[1:0], ra[1:0], b, 7'h00};
  endfunction : mk
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      summarize();
    end
  end
  initial
  begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, TMG_OFFSET, 32'h0);
    check(rd, 32'h0);
    check({31'h0, hresp}, 32'h0);
    bus(1'b1, TMG_OFFSET, 32'hFFFF_F7FF);
    bus(1'b0, TMG_OFFSET, 32'h0);
    check(rd, 32'h0000_F7FF);
    bus(1'b1, 8'h0C, 32'h1);
    bus(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, CFG_OFFSET, 32'h1);
    bus(1'b0, STAT_OFFSET, 32'h0);
    check(rd, 32'h0000_0060);
    $display("registers done");
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, TMG_OFFSET, mk(c, 3 - c, c % 3, c, 1'b0));
      acc(1'b0, 13'h0011);
      check(g(CMD_READ), 32'(4 - c));
      check({31'h0, p.ap_reg}, 32'h1);
      check({19'h0, p.act_row_reg}, 32'h11);
      acc(1'b1, 13'h0011);
      check(g(CMD_ACT), 32'(c + 1));
      acc(1'b0, 13'h0012);
      check(g(CMD_ACT), 32'(c + 2 + c % 3));
      idle(1);
      refresh_req <= 1'b1;
      @(posedge mclk);
      refresh_req <= 1'b0;
      acc(1'b0, 13'h0013);
      idle(8);
      check(g(CMD_REF), 32'(c));
      check(g(CMD_ACT), 32'(2 * c + 3));
    end
    $display("auto mode done");
    bus(1'b1, TMG_OFFSET, mk(1, 0, 1, 0, 1'b1));
    acc(1'b0, 13'h0005);
    acc(1'b0, 13'h0005);
    check(32'(p.prev_of[CMD_READ]), 32'(CMD_READ));
    check({31'h0, p.ap_reg}, 32'h0);
    acc(1'b0, 13'h0006);
    check(g(CMD_ACT), 32'h1);
    check({19'h0, p.act_row_reg}, 32'h6);
    acc(1'b1, 13'h0006);
    acc(1'b0, 13'h0007);
    check(g(CMD_PRE), 32'h2);
    idle(8);
    $display("bank mode done");
    bus(1'b1, TMG_OFFSET, mk(0, 0, 0, 0, 1'b0));
    srx(d0);
    bus(1'b1, TMG_OFFSET, mk(3, 0, 0, 0, 1'b0));
    srx(d3);
    check(32'(d3 - d0), 32'h9);
    $display("self refresh done");
    bus(1'b1, CFG_OFFSET, 32'h0);
    bus(1'b1, TMG_OFFSET, mk(2, 0, 2, 0, 1'b0));
    acc(1'b1, 13'h0008);
    acc(1'b0, 13'h0008);
    check(g(CMD_ACT), 32'h3);
    idle(8);
    $display("memory select done");
    reset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, TMG_OFFSET, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, STAT_OFFSET, 32'h0);
    check(rd, 32'h0000_0040);
    $display("reset done");
    summarize();
  end
endmodule : tb
`default_nettype wire
